// [pkg/seq_params.svh]
`ifndef SEQ_PARAMS_SVH
`define SEQ_PARAMS_SVH
`define ADDR_W 7
`define CODE_W 10
`define OFS_W 4
`define TWOWIRE_BASE_RST 7'h00
`define MGMT_BASE_RST 7'h00
`define CLK_MHZ 125
`define MS_US 1000
`define MS_CYC (`CLK_MHZ * `MS_US)
`define DEF_RISE_MS 7'h06
`define DEF_DELAY_MS 7'h00
`define REF_FULL 16'hffff
`define LS_STEPS 4'h8
`define LS_CYC_PER_STEP 5'h10
`define FLOAT_CODE 10'h3f0
`endif

// [pkg/seq_pkg.sv]
package seq_pkg;
   typedef enum logic [5:0] {
      ST_RESET = 6'h01,
      ST_LOAD = 6'h02,
      ST_SAMPLE = 6'h04,
      ST_WAIT = 6'h08,
      ST_DELAY = 6'h10,
      ST_RAMP = 6'h20
   } seq_state_t;
endpackage

// [logic/addr_mode_softstart_sequencer.sv]
// Behaviour
// - Two separate 7-bit base addresses, two-wire and management bus.
// - A base address of zero disables that bus.
// - Bases come from stored defaults; strap adds an offset.
// - Strap sampled once at init with 10-bit converter; offset latched.
// - Strap code decodes into sixteen ascending offsets, +0 to +15.
// - After load, bus answers only at base plus latched offset: digital mode.
// - Floating strap: analog mode, bus ignored, pins repurposed, config frozen.
// - Conversion enabled only with enable and bus-voltage comparators both above.
// - Digital mode: bus on/off thresholds reprogrammable, overriding default.
// - Digitized input voltage is telemetry only, never used for decisions.
// - Low-side switch off until first high-side pulse at pre-biased start.
// - Low-side on-time starts 1/8 period, 1/8 steps, 16 cycles each.
// - Soft-start begins only after enable, lockout and full load.
// - Analog or default: reference rises linearly to full over 6 ms.
// - Digital mode: programmable soft-start delay 0 to 127 ms, 1 ms steps.
// - Digital mode: programmable rise time 1 to 127 ms, 1 ms steps.
// - Over-current and over-voltage protection active during start-up.
// - Hold reset until supplies and oscillator good, then load store.
// - Default configuration: conversion also waits for address read.
`timescale 1ns/1ns
`include "seq_params.svh"
module addr_mode_softstart_sequencer #(
   parameter int MS_CYCLES = `MS_CYC
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Supply monitor and oscillator status
   input wire logic supplies_good,
   input wire logic osc_stable,
   // Reprogrammable store load port
   input wire logic store_valid,
   input wire logic [6:0] store_twowire_base,
   input wire logic [6:0] store_mgmt_base,
   input wire logic [6:0] store_delay_ms,
   input wire logic [6:0] store_rise_ms,
   // Configuration writes from the bus engine
   input wire logic cfg_we,
   input wire logic [1:0] cfg_sel,
   input wire logic [6:0] cfg_data,
   // Strap converter
   input wire logic strap_valid,
   input wire logic [9:0] strap_code,
   // Comparators
   input wire logic enable_pin,
   input wire logic vin_def_above,
   input wire logic vin_prog_above,
   input wire logic vin_prog_sel,
   input wire logic overcurrent,
   input wire logic overvoltage,
   // Switching cycle and high-side pulse markers
   input wire logic cycle_tick,
   input wire logic high_side_pulse,
   // Status and control outputs
   output logic digital_mode,
   output logic twowire_en,
   output logic mgmt_bus_en,
   output logic [6:0] twowire_addr,
   output logic [6:0] mgmt_bus_addr,
   output logic strap_sample_req,
   output logic convert_en,
   output logic protect_en,
   output logic low_side_allow,
   output logic [3:0] low_side_eighths,
   output logic [15:0] ref_level
);
   // Synchronised pins
   logic en_s1_ff, en_s2_ff, vd_s1_ff, vd_s2_ff, vp_s1_ff, vp_s2_ff;
   // Supply and oscillator monitors are analog, so they are synchronised too
   logic ps_s1_ff, ps_s2_ff, os_s1_ff, os_s2_ff;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         {en_s1_ff, en_s2_ff, vd_s1_ff, vd_s2_ff, vp_s1_ff, vp_s2_ff} <= 6'h00;
         {ps_s1_ff, ps_s2_ff, os_s1_ff, os_s2_ff} <= 4'h0;
      end else begin
         ps_s1_ff <= supplies_good;
         ps_s2_ff <= ps_s1_ff;
         os_s1_ff <= osc_stable;
         os_s2_ff <= os_s1_ff;
         en_s1_ff <= enable_pin;
         en_s2_ff <= en_s1_ff;
         vd_s1_ff <= vin_def_above;
         vd_s2_ff <= vd_s1_ff;
         vp_s1_ff <= vin_prog_above;
         vp_s2_ff <= vp_s1_ff;
      end
   end

   seq_pkg::seq_state_t state_ff, nxt_state;
   logic [6:0] tw_base_ff, mg_base_ff, delay_ff, rise_ff;
   logic [3:0] ofs_ff;
   logic dig_ff, prog_ff;
   logic [31:0] ms_cnt_ff;
   logic [6:0] ms_ff;
   logic [15:0] ref_ff;
   logic conv_ff, ls_allow_ff;
   logic [3:0] ls_ff;
   logic [4:0] ls_cnt_ff;

   // Strap decode: midpoints between the sixteen resistor codes
   logic [3:0] dec_ofs;
   logic strap_float;
   assign strap_float = strap_code >= `FLOAT_CODE;
   always_comb begin
      dec_ofs = 4'h0;
      for (int i = 1; i < 16; i++) begin
         if (strap_code >= 10'(i * 64 - 32)) begin
            dec_ofs = 4'(i);
         end
      end
   end

   wire power_ok = ps_s2_ff && os_s2_ff;
   // Lockout uses comparators only, never the digitised input voltage
   wire vin_ok = (dig_ff && prog_ff) ? vp_s2_ff : vd_s2_ff;
   wire start_ok = en_s2_ff && vin_ok;
   wire cfg_open = dig_ff && (state_ff != seq_pkg::ST_LOAD);
   wire ms_tick = ms_cnt_ff == 32'(MS_CYCLES - 1);
   wire [6:0] rise_eff = (rise_ff == 7'h00) ? 7'h01 : rise_ff;
   wire [22:0] ref_calc = 23'({16'h0000, ms_ff} * 23'(`REF_FULL) / 23'(rise_eff));

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         seq_pkg::ST_RESET: if (power_ok) nxt_state = seq_pkg::ST_LOAD;
         seq_pkg::ST_LOAD: if (store_valid) nxt_state = seq_pkg::ST_SAMPLE;
         seq_pkg::ST_SAMPLE: if (strap_valid) nxt_state = seq_pkg::ST_WAIT;
         seq_pkg::ST_WAIT: if (start_ok) nxt_state = seq_pkg::ST_DELAY;
         seq_pkg::ST_DELAY: begin
            if (!start_ok) nxt_state = seq_pkg::ST_WAIT;
            else if (ms_ff >= delay_ff) nxt_state = seq_pkg::ST_RAMP;
         end
         seq_pkg::ST_RAMP: if (!start_ok) nxt_state = seq_pkg::ST_WAIT;
         default: nxt_state = seq_pkg::ST_RESET;
      endcase
      if (!power_ok) nxt_state = seq_pkg::ST_RESET;
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_ff <= seq_pkg::ST_RESET;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Stored configuration, strap result and programmable overrides
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         tw_base_ff <= `TWOWIRE_BASE_RST;
         mg_base_ff <= `MGMT_BASE_RST;
         delay_ff <= `DEF_DELAY_MS;
         rise_ff <= `DEF_RISE_MS;
         ofs_ff <= 4'h0;
         dig_ff <= 1'b0;
         prog_ff <= 1'b0;
      end else begin
         if (state_ff == seq_pkg::ST_LOAD && store_valid) begin
            tw_base_ff <= store_twowire_base;
            mg_base_ff <= store_mgmt_base;
            delay_ff <= store_delay_ms;
            rise_ff <= store_rise_ms;
         end
         if (state_ff == seq_pkg::ST_SAMPLE && strap_valid) begin
            ofs_ff <= strap_float ? 4'h0 : dec_ofs;
            dig_ff <= !strap_float;
         end
         if (cfg_we && cfg_open) begin
            case (cfg_sel)
               2'h0: delay_ff <= cfg_data;
               2'h1: rise_ff <= cfg_data;
               2'h2: tw_base_ff <= cfg_data;
               default: prog_ff <= cfg_data[0] | vin_prog_sel;
            endcase
         end
      end
   end

   // Millisecond timebase and reference ramp
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ms_cnt_ff <= 32'h0;
         ms_ff <= 7'h00;
         ref_ff <= 16'h0000;
      end else if (nxt_state != state_ff || state_ff == seq_pkg::ST_WAIT) begin
         ms_cnt_ff <= 32'h0;
         ms_ff <= 7'h00;
         if (nxt_state != seq_pkg::ST_RAMP) ref_ff <= 16'h0000;
      end else begin
         ms_cnt_ff <= ms_tick ? 32'h0 : ms_cnt_ff + 32'h1;
         if (ms_tick && ms_ff != 7'h7f) ms_ff <= ms_ff + 7'h01;
         if (state_ff == seq_pkg::ST_RAMP) begin
            ref_ff <= (ms_ff >= rise_eff) ? `REF_FULL : ref_calc[15:0];
         end
      end
   end

   // Pre-bias low-side ramp
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ls_allow_ff <= 1'b0;
         ls_ff <= 4'h0;
         ls_cnt_ff <= 5'h00;
         conv_ff <= 1'b0;
      end else begin
         conv_ff <= (nxt_state == seq_pkg::ST_DELAY) || (nxt_state == seq_pkg::ST_RAMP);
         if (!conv_ff) begin
            ls_allow_ff <= 1'b0;
            ls_ff <= 4'h0;
            ls_cnt_ff <= 5'h00;
         end else if (!ls_allow_ff) begin
            if (high_side_pulse) begin
               ls_allow_ff <= 1'b1;
               ls_ff <= 4'h1;
            end
         end else if (cycle_tick && ls_ff != `LS_STEPS) begin
            if (ls_cnt_ff == `LS_CYC_PER_STEP - 5'h01) begin
               ls_cnt_ff <= 5'h00;
               ls_ff <= ls_ff + 4'h1;
            end else begin
               ls_cnt_ff <= ls_cnt_ff + 5'h01;
            end
         end
      end
   end

   // Registered outputs
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         digital_mode <= 1'b0;
         twowire_en <= 1'b0;
         mgmt_bus_en <= 1'b0;
         twowire_addr <= 7'h00;
         mgmt_bus_addr <= 7'h00;
         strap_sample_req <= 1'b0;
         protect_en <= 1'b0;
      end else begin
         digital_mode <= dig_ff;
         twowire_en <= dig_ff && tw_base_ff != 7'h00;
         mgmt_bus_en <= dig_ff && mg_base_ff != 7'h00;
         twowire_addr <= tw_base_ff + {3'h0, ofs_ff};
         mgmt_bus_addr <= mg_base_ff + {3'h0, ofs_ff};
         strap_sample_req <= nxt_state == seq_pkg::ST_SAMPLE;
         protect_en <= state_ff != seq_pkg::ST_RESET;
      end
   end

   assign convert_en = conv_ff;
   assign low_side_allow = ls_allow_ff;
   assign low_side_eighths = ls_ff;
   assign ref_level = ref_ff;

   chk_bus_off_zero: assert property (@(posedge mclk) disable iff (rst)
      (mg_base_ff == 7'h00) |=> !mgmt_bus_en) else $error("bus live at zero base");
   chk_analog_silent: assert property (@(posedge mclk) disable iff (rst)
      !dig_ff |=> !twowire_en && !mgmt_bus_en) else $error("analog mode bus live");
   chk_conv_needs_en: assert property (@(posedge mclk) disable iff (rst)
      $rose(convert_en) |-> $past(en_s2_ff)) else $error("conversion without enable");
   chk_ls_off_first: assert property (@(posedge mclk) disable iff (rst)
      $rose(low_side_allow) |-> $past(high_side_pulse)) else $error("low side early");
   chk_ls_first_step: assert property (@(posedge mclk) disable iff (rst)
      $rose(low_side_allow) |-> low_side_eighths == 4'h1) else $error("bad first step");
   chk_ramp_after_ok: assert property (@(posedge mclk) disable iff (rst)
      (state_ff == seq_pkg::ST_RAMP) |-> $past(start_ok)) else $error("ramp without ok");
   chk_ref_zero_wait: assert property (@(posedge mclk) disable iff (rst)
      (state_ff == seq_pkg::ST_WAIT) |=> ref_level == 16'h0000) else $error("ref not zero");
   chk_protect_live: assert property (@(posedge mclk) disable iff (rst)
      convert_en |-> protect_en) else $error("protection off in start-up");
   chk_load_after_por: assert property (@(posedge mclk) disable iff (rst)
      (state_ff == seq_pkg::ST_LOAD) |-> $past(power_ok)) else $error("load before power");

   // Mode and offset stay as latched once the strap has been read
   chk_mode_latched: assert property (@(posedge mclk) disable iff (rst)
      (state_ff != seq_pkg::ST_SAMPLE) |=> $stable(dig_ff)) else $error("mode moved");
   chk_ofs_latched: assert property (@(posedge mclk) disable iff (rst)
      (state_ff != seq_pkg::ST_SAMPLE) |=> $stable(ofs_ff)) else $error("offset moved");

   // Bus enables follow the base values
   chk_tw_off_zero: assert property (@(posedge mclk) disable iff (rst)
      (tw_base_ff == 7'h00) |=> !twowire_en) else $error("two-wire live at zero base");
   chk_tw_live: assert property (@(posedge mclk) disable iff (rst)
      (dig_ff && tw_base_ff != 7'h00) |=> twowire_en) else $error("two-wire bus dead");
   chk_mg_live: assert property (@(posedge mclk) disable iff (rst)
      (dig_ff && mg_base_ff != 7'h00) |=> mgmt_bus_en) else $error("management bus dead");

   // Analog mode keeps the loaded timing untouched
   chk_cfg_frozen: assert property (@(posedge mclk) disable iff (rst)
      (!dig_ff && state_ff != seq_pkg::ST_LOAD) |=> $stable(delay_ff) && $stable(rise_ff))
      else $error("config changed in analog mode");

   // Low-side ramp only runs while converting and never passes full duty
   chk_ls_needs_conv: assert property (@(posedge mclk) disable iff (rst)
      low_side_allow |-> $past(convert_en)) else $error("low side without conversion");
   chk_ls_step_cap: assert property (@(posedge mclk) disable iff (rst)
      low_side_eighths <= 4'h8) else $error("low side step overflow");

   // Start-up ordering
   chk_ref_zero_delay: assert property (@(posedge mclk) disable iff (rst)
      (state_ff == seq_pkg::ST_DELAY) |=> ref_level == 16'h0000) else $error("ref moved in delay");
   chk_no_conv_reset: assert property (@(posedge mclk) disable iff (rst)
      (state_ff == seq_pkg::ST_RESET) |=> !convert_en) else $error("conversion in reset");
   chk_conv_after_addr: assert property (@(posedge mclk) disable iff (rst)
      convert_en |-> ($past(state_ff) == seq_pkg::ST_WAIT || $past(state_ff) == seq_pkg::ST_DELAY
      || $past(state_ff) == seq_pkg::ST_RAMP)) else $error("conversion before address read");
endmodule

// [tb/strap_host_model.sv]
`timescale 1ns/1ns
module strap_host_model (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Strap request and resistor setting
   input wire logic sample_req,
   input wire logic [9:0] code_set,
   // Status and converter result
   output logic supplies_good,
   output logic osc_stable,
   output logic strap_valid,
   output logic [9:0] strap_code
);
   logic [2:0] conv_ff;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         supplies_good <= 1'b0;
         osc_stable <= 1'b0;
         strap_valid <= 1'b0;
         strap_code <= 10'h000;
         conv_ff <= 3'h0;
      end else begin
         // Oscillator settles one cycle after the supplies
         supplies_good <= 1'b1;
         osc_stable <= supplies_good;
         // One conversion only; the code is valid for a single cycle
         if (sample_req && conv_ff != 3'h7)
            conv_ff <= conv_ff + 3'h1;
         strap_valid <= sample_req && conv_ff == 3'h3;
         strap_code <= (conv_ff == 3'h3) ? code_set : ~code_set;
      end
   end
endmodule

// [tb/addr_mode_softstart_sequencer_test.sv]
`timescale 1ns/1ns
module addr_mode_softstart_sequencer_test;
   localparam int MS = 10;
   logic mclk = 1'b0, rst = 1'b1, store_valid = 1'b1, cfg_we = 1'b0, enable_pin = 1'b0;
   logic vin_def_above = 1'b0, cycle_tick = 1'b0, high_side_pulse = 1'b0;
   logic [6:0] store_twowire_base = 7'h00, store_mgmt_base = 7'h00, store_delay_ms = 7'h00;
   logic [6:0] store_rise_ms = 7'h06, cfg_data = 7'h00;
   logic [1:0] cfg_sel = 2'h0;
   logic [9:0] code_set = 10'h000, strap_code;
   logic supplies_good, osc_stable, strap_valid, digital_mode, twowire_en, mgmt_bus_en;
   logic strap_sample_req, convert_en, protect_en, low_side_allow;
   logic [6:0] twowire_addr, mgmt_bus_addr;
   logic [3:0] low_side_eighths;
   logic [15:0] ref_level;
   logic [31:0] expq[$];
   logic [31:0] seen_v;
   int n_mismatch = 0;
   int compares = 0;
   int seed = 44;
   int v;
   initial begin
      forever #4 mclk = ~mclk;
   end
   strap_host_model host (.mclk, .rst, .sample_req(strap_sample_req), .code_set,
      .supplies_good, .osc_stable, .strap_valid, .strap_code);
   addr_mode_softstart_sequencer #(.MS_CYCLES(MS)) dut (.mclk, .rst, .supplies_good,
      .osc_stable, .store_valid, .store_twowire_base, .store_mgmt_base, .store_delay_ms,
      .store_rise_ms, .cfg_we, .cfg_sel, .cfg_data, .strap_valid, .strap_code, .enable_pin,
      .vin_def_above, .vin_prog_above(1'b0), .vin_prog_sel(1'b0), .overcurrent(1'b0),
      .overvoltage(1'b0), .cycle_tick, .high_side_pulse, .digital_mode, .twowire_en,
      .mgmt_bus_en, .twowire_addr, .mgmt_bus_addr, .strap_sample_req, .convert_en,
      .protect_en, .low_side_allow, .low_side_eighths, .ref_level);
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Address and mode are judged as conversion starts
   always @(posedge convert_en) begin
      seen_v = {digital_mode, twowire_en, mgmt_bus_en, 29'h0};
      if (digital_mode === 1'b1)
         seen_v[28:15] = {twowire_addr, mgmt_bus_addr};
      if (expq.size() == 0)
         check(32'h0, 32'h1);
      else
         check(seen_v, expq.pop_front());
   end
   task automatic run(input logic [6:0] tw, mg, dl, rc, input logic [3:0] off, input logic fl);
      int n;
      int r;
      r = fl ? 6 : int'(rc) + int'(dl);
      @(posedge mclk);
      rst <= 1'b1;
      enable_pin <= 1'b0;
      vin_def_above <= 1'b1;
      store_twowire_base <= tw;
      store_mgmt_base <= mg;
      store_delay_ms <= fl ? 7'h00 : dl;
      code_set <= fl ? 10'h3ff : {off, 6'h00};
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      repeat (30) @(posedge mclk);
      cfg_we <= 1'b1;
      cfg_sel <= 2'h1;
      cfg_data <= rc;
      @(posedge mclk);
      cfg_we <= 1'b0;
      repeat (8) @(posedge mclk);
      check({31'h0, convert_en}, 32'h0);
      expq.push_back({~fl, ~fl && tw != 0, ~fl && mg != 0, fl ? 14'h0 : {tw + off, mg + off}, 15'h0});
      enable_pin <= 1'b1;
      n = 0;
      while (convert_en !== 1'b1 && n < 40) begin
         @(posedge mclk);
         n++;
      end
      #1;
      check({31'h0, low_side_allow}, 32'h0);
      check({31'h0, protect_en}, 32'h1);
      n = 0;
      while (ref_level !== 16'hffff && n < 300 * MS) begin
         @(posedge mclk);
         n++;
         if (!fl && n == int'(dl) * MS - 4)
            check({16'h0, ref_level}, 32'h0);
      end
      check({31'h0, n >= r * MS - 4 && n <= r * MS + 4}, 32'h1);
      high_side_pulse <= 1'b1;
      @(posedge mclk);
      high_side_pulse <= 1'b0;
      repeat (3) @(posedge mclk);
      check({31'h0, low_side_allow}, 32'h1);
      check({28'h0, low_side_eighths}, 32'h1);
      repeat (16) begin
         cycle_tick <= 1'b1;
         @(posedge mclk);
         cycle_tick <= 1'b0;
         @(posedge mclk);
      end
      repeat (3) @(posedge mclk);
      check({28'h0, low_side_eighths}, 32'h2);
      enable_pin <= 1'b0;
      repeat (6) @(posedge mclk);
      check({15'h0, convert_en, ref_level}, 32'h0);
      $display("test done base=%h offset=%h float=%0d", tw, off, fl);
   endtask
   initial begin
      repeat (2) @(posedge mclk);
      for (int k = 0; k < 4; k++) begin
         v = $random(seed);
         run(7'h01 + v[5:0], 7'h40 + v[10:6], v[12:11], v[14:13] + 7'h1, v[18:15], 1'b0);
      end
      run(7'h70, 7'h01, 7'h00, 7'h01, 4'hf, 1'b0);
      run(7'h00, 7'h30, 7'h01, 7'h02, 4'h0, 1'b0);
      // Floating strap: the rise write must be ignored
      run(7'h12, 7'h00, 7'h00, 7'h01, 4'h3, 1'b1);
      end_of_test();
   end
   initial begin
      repeat (20000) @(posedge mclk);
      n_mismatch++;
      end_of_test();
   end
endmodule
